// ---- shared/ecld_pkg.sv ----
// Constants and types shared by the eight channel LED PWM driver
package ecld_pkg;
    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLOCK_HZ = 40_000_000;
    localparam int CLOCK_NS = 25;
    localparam int PWM_HZ = 97_000;
    localparam int PWM_STEPS = 256;
    localparam int STEP_INC = PWM_HZ * PWM_STEPS;
    localparam int GROUP_DIM_HZ = 190;
    localparam int GROUP_DIM_DIV = (PWM_HZ + GROUP_DIM_HZ * PWM_STEPS / 2)
        / (GROUP_DIM_HZ * PWM_STEPS);
    localparam int BLINK_MAX_HZ = 24;
    localparam int BLINK_DIV = PWM_HZ / (BLINK_MAX_HZ * PWM_STEPS);
    localparam int SPIKE_NS = 50;
    localparam int SPIKE_CYCLES = (SPIKE_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int FILT_CYCLES = SPIKE_CYCLES + 1;
    // ************************************************************
    // Internal register map, reached through the serial bus
    // ************************************************************
    localparam int REG_COUNT = 17;
    localparam logic [4:0] REG_MODE = 5'h00;
    localparam logic [4:0] REG_BRIGHT0 = 5'h01;
    localparam logic [4:0] REG_GROUP_DUTY = 5'h09;
    localparam logic [4:0] REG_GROUP_FREQ = 5'h0A;
    localparam logic [4:0] REG_OUT_LO = 5'h0B;
    localparam logic [4:0] REG_OUT_HI = 5'h0C;
    localparam logic [4:0] REG_SUB1 = 5'h0D;
    localparam logic [4:0] REG_GROUP_ADDR = 5'h10;
    localparam int MODE_GROUP_EN_BIT = 0;
    localparam int MODE_SUB_EN_LSB = 1;
    localparam int MODE_BLINK_BIT = 4;
    localparam logic [7:0] MODE_RESET = 8'h01;
    localparam logic [7:0] GROUP_DUTY_RESET = 8'hFF;
    localparam logic [7:0] SUB_ADDR_RESET = 8'h92;
    localparam logic [7:0] GROUP_ADDR_RESET = 8'hD0;
    // ************************************************************
    // Bus addresses and the soft reset call
    // ************************************************************
    localparam logic [3:0] ADDR_FIXED_HIGH = 4'h2;
    localparam logic [6:0] SOFT_RESET_ADDR = 7'h4F;
    localparam logic [7:0] SOFT_RESET_KEY1 = 8'hA5;
    localparam logic [7:0] SOFT_RESET_KEY2 = 8'h5A;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_DONE = 4'h9;
    typedef enum {ST_IDLE, ST_ADDR, ST_WRITE, ST_READ, ST_SOFT, ST_IGNORE} ecld_bus_e;
    typedef enum logic [1:0] {LED_OFF, LED_ON, LED_INDIV, LED_GROUP} ecld_led_e;
endpackage : ecld_pkg

// ---- hdl/ecld_led_driver.sv ----
// Eight channel LED PWM driver with a serial bus slave
`timescale 1ns/1ps
module ecld_led_driver
    import ecld_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic resetPinN,
    input wire logic [2:0] addrPin,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic [7:0] ledOut,
    output logic [7:0] ledOe
);
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [1:0] chanMode(input logic [7:0] lo, input logic [7:0] hi,
                                            input int ch);
        logic [15:0] all;
        all = {hi, lo};
        return all[2*ch +: 2];
    endfunction : chanMode

    function automatic logic [4:0] nextPtr(input logic [4:0] p);
        return (p == 5'(REG_COUNT - 1)) ? 5'h00 : p + 5'h01;
    endfunction : nextPtr

    function automatic logic [7:0] resetValue(input int idx);
        if (idx == int'(REG_MODE)) return MODE_RESET;
        if (idx == int'(REG_GROUP_DUTY)) return GROUP_DUTY_RESET;
        if (idx >= int'(REG_SUB1) && idx < int'(REG_GROUP_ADDR)) return SUB_ADDR_RESET;
        if (idx == int'(REG_GROUP_ADDR)) return GROUP_ADDR_RESET;
        return 8'h00;
    endfunction : resetValue

    // ************************************************************
    // Input synchronisers, spike filter and reset merge
    // ************************************************************
    logic [1:0] sync1_reg, sync2_reg, filt_reg, filt_next;
    logic [1:0] cnt_reg [2];
    logic [1:0] cnt_next [2];
    logic [2:0] addrS1_reg, addrS2_reg;
    logic pinS1_reg, pinS2_reg, soft_reg, soft_next, rstAll;

    // Pin reset is caught through two flops so it cannot go metastable
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pinS1_reg <= 1'b1;
            pinS2_reg <= 1'b1;
        end
        else
        begin
            pinS1_reg <= resetPinN;
            pinS2_reg <= pinS1_reg;
        end
    end

    assign rstAll = reset || !pinS2_reg || soft_reg;

    // A level is taken only after FILT_CYCLES equal samples
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            filt_next[i] = filt_reg[i];
            cnt_next[i] = 2'h0;
            if (sync2_reg[i] != filt_reg[i])
            begin
                cnt_next[i] = cnt_reg[i] + 2'h1;
                if (cnt_reg[i] == 2'(FILT_CYCLES - 1))
                begin
                    filt_next[i] = sync2_reg[i];
                    cnt_next[i] = 2'h0;
                end
            end
        end
    end

    always_ff @(posedge clock)
    begin
        sync1_reg <= {sdaIn, sclIn};
        sync2_reg <= sync1_reg;
        addrS1_reg <= addrPin;
        addrS2_reg <= addrS1_reg;
        if (reset)
        begin
            filt_reg <= 2'b11;
            cnt_reg <= '{2'h0, 2'h0};
        end
        else
        begin
            filt_reg <= filt_next;
            cnt_reg <= cnt_next;
        end
    end

    logic sclF, sdaF, sclRise, sclFall, busStart, busStop;
    assign sclF = filt_reg[0];
    assign sdaF = filt_reg[1];
    assign sclRise = filt_next[0] && !sclF;
    assign sclFall = !filt_next[0] && sclF;
    assign busStart = sclF && filt_next[0] && sdaF && !filt_next[1];
    assign busStop = sclF && filt_next[0] && !sdaF && filt_next[1];

    // ************************************************************
    // Bus slave and register file
    // ************************************************************
    ecld_bus_e state_reg, state_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] rx_reg, rx_next, tx_reg, tx_next;
    logic [7:0] regs_reg [REG_COUNT];
    logic [7:0] regs_next [REG_COUNT];
    logic [4:0] ptr_reg, ptr_next;
    logic [1:0] key_reg, key_next;
    logic first_reg, first_next, oe_reg, oe_next, nack_reg, nack_next, hit;
    logic [7:0] mode;
    assign mode = regs_reg[REG_MODE];

    // Address match on own, enabled group call and enabled sub addresses
    always_comb
    begin
        hit = rx_reg[7:1] == {ADDR_FIXED_HIGH, addrS2_reg};
        if (mode[MODE_GROUP_EN_BIT] && rx_reg[7:1] == regs_reg[REG_GROUP_ADDR][7:1])
            hit = 1'b1;
        for (int s = 0; s < 3; s++)
        begin
            if (mode[MODE_SUB_EN_LSB + s] && rx_reg[7:1] == regs_reg[int'(REG_SUB1) + s][7:1])
                hit = 1'b1;
        end
    end

    // Bytes commit at the acknowledge, so each write takes effect byte by byte
    always_comb
    begin
        state_next = state_reg;
        bit_next = bit_reg;
        rx_next = rx_reg;
        tx_next = tx_reg;
        regs_next = regs_reg;
        ptr_next = ptr_reg;
        key_next = key_reg;
        first_next = first_reg;
        oe_next = oe_reg;
        nack_next = nack_reg;
        soft_next = 1'b0;
        if (busStart)
        begin
            state_next = ST_ADDR;
            bit_next = 4'h0;
            oe_next = 1'b0;
            key_next = 2'h0;
        end
        else if (busStop)
        begin
            state_next = ST_IDLE;
            oe_next = 1'b0;
            soft_next = (state_reg == ST_SOFT) && (key_reg == 2'h2);
        end
        else if (state_reg != ST_IDLE && state_reg != ST_IGNORE && sclRise)
        begin
            if (bit_reg < BIT_ACK)
            begin
                rx_next = {rx_reg[6:0], sdaF};
                bit_next = bit_reg + 4'h1;
            end
            else if (bit_reg == BIT_DONE)
                nack_next = sdaF;
        end
        else if (state_reg != ST_IDLE && state_reg != ST_IGNORE && sclFall)
        begin
            if (bit_reg == BIT_ACK)
            begin
                bit_next = BIT_DONE;
                oe_next = 1'b1;
                nack_next = 1'b0;
                unique case (state_reg)
                    ST_ADDR:
                        if (rx_reg == {SOFT_RESET_ADDR, 1'b0})
                            state_next = ST_SOFT;
                        else if (hit)
                        begin
                            state_next = rx_reg[0] ? ST_READ : ST_WRITE;
                            first_next = 1'b1;
                        end
                        else
                        begin
                            state_next = ST_IGNORE;
                            oe_next = 1'b0;
                        end
                    ST_WRITE:
                    begin
                        first_next = 1'b0;
                        if (first_reg)
                            ptr_next = rx_reg[4:0];
                        else if (ptr_reg < 5'(REG_COUNT))
                        begin
                            regs_next[ptr_reg] = rx_reg;
                            ptr_next = nextPtr(ptr_reg);
                        end
                    end
                    ST_SOFT:
                        if ((key_reg == 2'h0 && rx_reg == SOFT_RESET_KEY1)
                            || (key_reg == 2'h1 && rx_reg == SOFT_RESET_KEY2))
                            key_next = key_reg + 2'h1;
                        else
                        begin
                            state_next = ST_IGNORE;
                            key_next = 2'h0;
                            oe_next = 1'b0;
                        end
                    ST_READ:
                        oe_next = 1'b0;
                    default:
                        oe_next = 1'b0;
                endcase
            end
            else if (bit_reg == BIT_DONE)
            begin
                bit_next = 4'h0;
                oe_next = 1'b0;
                if (state_reg == ST_READ && nack_reg)
                    state_next = ST_IGNORE;
                else if (state_reg == ST_READ)
                begin
                    tx_next = (ptr_reg < 5'(REG_COUNT)) ? regs_reg[ptr_reg] : 8'h00;
                    oe_next = !tx_next[7];
                    tx_next = {tx_next[6:0], 1'b0};
                    ptr_next = nextPtr(ptr_reg);
                end
            end
            else if (state_reg == ST_READ)
            begin
                oe_next = !tx_reg[7];
                tx_next = {tx_reg[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rstAll)
        begin
            state_reg <= ST_IDLE;
            bit_reg <= 4'h0;
            rx_reg <= 8'h00;
            tx_reg <= 8'h00;
            ptr_reg <= 5'h00;
            key_reg <= 2'h0;
            first_reg <= 1'b0;
            oe_reg <= 1'b0;
            nack_reg <= 1'b0;
            for (int r = 0; r < REG_COUNT; r++)
                regs_reg[r] <= resetValue(r);
        end
        else
        begin
            state_reg <= state_next;
            bit_reg <= bit_next;
            rx_reg <= rx_next;
            tx_reg <= tx_next;
            ptr_reg <= ptr_next;
            key_reg <= key_next;
            first_reg <= first_next;
            oe_reg <= oe_next;
            nack_reg <= nack_next;
            regs_reg <= regs_next;
        end
        soft_reg <= reset ? 1'b0 : soft_next;
    end

    // ************************************************************
    // PWM timebase, group PWM and outputs
    // ************************************************************
    logic [25:0] acc_reg, acc_next;
    logic [7:0] pwm_reg, pwm_next, grp_reg, grp_next;
    logic [11:0] pre_reg, pre_next, preLimit;
    logic [7:0] led_reg, led_next;
    logic tick, periodEnd, groupStep;

    // Fractional accumulator holds the average step rate at 256 x 97 kHz
    always_comb
    begin
        acc_next = acc_reg + 26'(STEP_INC);
        tick = acc_next >= 26'(CLOCK_HZ);
        if (tick)
            acc_next = acc_next - 26'(CLOCK_HZ);
        pwm_next = tick ? pwm_reg + 8'h01 : pwm_reg;
        periodEnd = tick && pwm_reg == 8'hFF;
        preLimit = mode[MODE_BLINK_BIT]
            ? 12'(BLINK_DIV) * (12'(regs_reg[REG_GROUP_FREQ]) + 12'h001)
            : 12'(GROUP_DIM_DIV);
        groupStep = periodEnd && pre_reg >= preLimit - 12'h001;
        pre_next = groupStep ? 12'h000 : (periodEnd ? pre_reg + 12'h001 : pre_reg);
        grp_next = groupStep ? grp_reg + 8'h01 : grp_reg;
        led_next = 8'h00;
        for (int c = 0; c < 8; c++)
        begin
            unique case (ecld_led_e'(chanMode(regs_reg[REG_OUT_LO], regs_reg[REG_OUT_HI], c)))
                LED_OFF: led_next[c] = 1'b0;
                LED_ON: led_next[c] = 1'b1;
                LED_INDIV: led_next[c] = pwm_reg < regs_reg[int'(REG_BRIGHT0) + c];
                LED_GROUP: led_next[c] = pwm_reg < regs_reg[int'(REG_BRIGHT0) + c]
                    && grp_reg < regs_reg[REG_GROUP_DUTY];
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (rstAll)
        begin
            acc_reg <= 26'h0000000;
            pwm_reg <= 8'h00;
            pre_reg <= 12'h000;
            grp_reg <= 8'h00;
            led_reg <= 8'h00;
        end
        else
        begin
            acc_reg <= acc_next;
            pwm_reg <= pwm_next;
            pre_reg <= pre_next;
            grp_reg <= grp_next;
            led_reg <= led_next;
        end
    end

    // Open drain: enable pulls the pin low and lights the LED
    assign ledOut = 8'h00;
    assign ledOe = led_reg;
    assign sdaOut = 1'b0;
    assign sdaOe = oe_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence softCallDone;
        busStop && state_reg == ST_SOFT && key_reg == 2'h2;
    endsequence
    sequence allDark;
        led_reg == 8'h00 && regs_reg[REG_OUT_LO] == 8'h00;
    endsequence

    // Channel 4 is the one the scenarios put on its own PWM
    indiv_pwm_a: assert property (!rstAll
        && chanMode(regs_reg[REG_OUT_LO], regs_reg[REG_OUT_HI], 4) == 2'(LED_INDIV)
        |=> ledOe[4] == $past(pwm_reg < regs_reg[int'(REG_BRIGHT0) + 4]))
        else $error("channel 4 PWM level wrong");
    group_dim_a: assert property (!rstAll && !mode[MODE_BLINK_BIT] && periodEnd
        && pre_reg == 12'(GROUP_DIM_DIV - 1) |=> grp_reg == $past(grp_reg) + 8'h01)
        else $error("group dim step missing");
    blink_rate_a: assert property (!rstAll && mode[MODE_BLINK_BIT] && periodEnd
        && pre_reg + 12'h001 < preLimit |=> $stable(grp_reg))
        else $error("blink group stepped early");
    led_off_a: assert property (!rstAll
        && chanMode(regs_reg[REG_OUT_LO], regs_reg[REG_OUT_HI], 1) == 2'(LED_OFF) |=> !ledOe[1])
        else $error("off channel driven");
    group_addr_a: assert property (!rstAll && state_reg == ST_ADDR && sclFall
        && bit_reg == BIT_ACK && mode[MODE_GROUP_EN_BIT]
        && rx_reg[7:1] == regs_reg[REG_GROUP_ADDR][7:1] && !busStart && !busStop |=> sdaOe)
        else $error("group call not acknowledged");
    soft_reset_a: assert property (softCallDone |=> soft_reg ##1 allDark)
        else $error("soft reset call did not clear outputs");
    reset_idle_a: assert property ($fell(reset)
        |-> state_reg == ST_IDLE && !sdaOe && ledOe == 8'h00)
        else $error("not idle after reset");
    spike_filter_a: assert property (!$stable(sclF)
        |-> $past(sync2_reg[0], 1) == sclF && $past(sync2_reg[0], 2) == sclF
        && $past(sync2_reg[0], 3) == sclF)
        else $error("short spike passed the filter");
    bad_key_a: assert property (!rstAll && state_reg == ST_SOFT && key_reg == 2'h0
        && sclFall && bit_reg == BIT_ACK && rx_reg != SOFT_RESET_KEY1
        && !busStart && !busStop |=> !sdaOe)
        else $error("wrong soft reset byte acknowledged");
    pin_reset_a: assert property (!pinS2_reg |=> state_reg == ST_IDLE && ledOe == 8'h00)
        else $error("pin reset did not hold defaults");
    step_only_a: assert property (!rstAll && !tick |=> $stable(pwm_reg))
        else $error("PWM counter moved without a step");
endmodule : ecld_led_driver

// ---- bench/ecld_bus_master.sv ----
// Two-wire bus master model that drives the LED driver's serial port
`timescale 1ns/1ps
module ecld_bus_master
(
    input wire logic clock,
    input wire logic sdaLine,
    output logic scl,
    output logic sdaDrive
);
    // ****************************************
    // Bit timing
    // ****************************************
    // Half bit of 12 clocks keeps both phases above the 8-clock minimum
    localparam int HALF = 12;
    // Data held past each clock fall, since the input filter lags both lines
    localparam int HOLD = 6;
    // Idle bus floats high through the pull-ups
    initial
    begin
        scl = 1'b1;
        sdaDrive = 1'b1;
    end
    // All changes land on the falling clock edge
    task automatic hold(input int n);
        repeat (n) @(negedge clock);
    endtask : hold
    // Start, or repeated start when the clock line is low
    task automatic start();
        sdaDrive = 1'b1;
        hold(HALF);
        scl = 1'b1;
        hold(HALF);
        sdaDrive = 1'b0;
        hold(HALF);
        scl = 1'b0;
        hold(HOLD);
    endtask : start
    // Stop, then bus free time before any next start
    task automatic stop();
        sdaDrive = 1'b0;
        hold(HALF);
        scl = 1'b1;
        hold(HALF);
        sdaDrive = 1'b1;
        hold(4 * HALF);
    endtask : stop
    // Eight bits MSB first, then the acknowledge slot with the line let go
    task automatic send(input logic [7:0] data, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            sdaDrive = data[i];
            hold(HALF);
            scl = 1'b1;
            hold(HALF);
            scl = 1'b0;
            hold(HOLD);
        end
        sdaDrive = 1'b1;
        hold(HALF);
        scl = 1'b1;
        hold(2);
        ack = ~sdaLine;
        hold(HALF - 2);
        scl = 1'b0;
        hold(HOLD);
    endtask : send
    // Eight bits taken two clocks after each clock rise, then our acknowledge; a refusal ends the read
    task automatic recv(input logic ackIt, output logic [7:0] data);
        sdaDrive = 1'b1;
        for (int i = 7; i >= 0; i--)
        begin
            hold(HALF);
            scl = 1'b1;
            hold(2);
            data[i] = sdaLine;
            hold(HALF - 2);
            scl = 1'b0;
            hold(HOLD);
        end
        sdaDrive = !ackIt;
        hold(HALF);
        scl = 1'b1;
        hold(HALF);
        scl = 1'b0;
        hold(HOLD);
    endtask : recv
    // One-cycle clock pulse, narrower than the filter must reject
    task automatic spike();
        scl = 1'b1;
        hold(1);
        scl = 1'b0;
        hold(HALF);
    endtask : spike
endmodule : ecld_bus_master

// ---- bench/eight_channel_led_pwm_driver_tb.sv ----
// Self-checking testbench for the eight channel LED PWM driver
`timescale 1ns/1ps
module eight_channel_led_pwm_driver_tb
    import ecld_pkg::*;
;
    // ****************************************
    // Clock, reset and bus wiring
    // ****************************************
    localparam logic [2:0] STRAP = 3'h5;
    localparam logic [7:0] OWN_W = {ADDR_FIXED_HIGH, STRAP, 1'b0};
    localparam logic [7:0] SOFT_W = {SOFT_RESET_ADDR, 1'b0};
    localparam int PWM_CYC = CLOCK_HZ / PWM_HZ;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic resetPinN = 1'b1;
    logic [2:0] addrPin = STRAP;
    logic scl;
    logic sdaDrive;
    logic sdaOe;
    logic [7:0] ledOe;
    logic sdaOut;
    logic [7:0] ledOut;
    logic sdaLine;
    int failCount = 0;
    int totalChecks = 0;
    // Pulled-up data line, low when either party pulls it
    assign sdaLine = sdaDrive & (sdaOe ? sdaOut : 1'b1);
    // 40 MHz clock
    initial
    begin
        forever #12.5 clock = ~clock;
    end
    ecld_bus_master i_master
    (
        .clock(clock),
        .sdaLine(sdaLine),
        .scl(scl),
        .sdaDrive(sdaDrive)
    );
    ecld_led_driver i_dut
    (
        .clock(clock),
        .reset(reset),
        .resetPinN(resetPinN),
        .addrPin(addrPin),
        .sclIn(scl),
        .sdaIn(sdaLine),
        .sdaOut(sdaOut),
        .sdaOe(sdaOe),
        .ledOut(ledOut),
        .ledOe(ledOe)
    );
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] expected);
        totalChecks++;
        if (seen !== expected)
        begin
            failCount++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask : check
    task automatic closeOut();
        $display("Checks %0d, mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : closeOut
    // Send one byte and judge the acknowledge
    task automatic tx(input logic [7:0] data, input logic expAck);
        logic ack;
        i_master.send(data, ack);
        check(8'(ack), 8'(expAck));
    endtask : tx
    // Single register write; refused addresses end at the stop
    task automatic wr(input logic [7:0] addr, input logic [4:0] ptr, input logic [7:0] data,
                      input logic expAck);
        i_master.start();
        tx(addr, expAck);
        if (expAck)
        begin
            tx({3'h0, ptr}, 1'b1);
            tx(data, 1'b1);
        end
        i_master.stop();
    endtask : wr
    // Set the pointer, then read two registers back, refusing the second
    task automatic rd(input logic [4:0] ptr, input logic [7:0] exp0, input logic [7:0] exp1);
        logic [7:0] data;
        i_master.start();
        tx(OWN_W, 1'b1);
        tx({3'h0, ptr}, 1'b1);
        i_master.stop();
        i_master.start();
        tx(OWN_W | 8'h01, 1'b1);
        i_master.recv(1'b1, data);
        check(data, exp0);
        i_master.recv(1'b0, data);
        i_master.stop();
        check(data, exp1);
    endtask : rd
    // Clocks with the channel pulled low over two PWM periods
    task automatic onTime(input int ch, output int n);
        n = 0;
        repeat (2 * PWM_CYC)
        begin
            @(negedge clock);
            if (ledOe[ch] === 1'b1)
                n++;
        end
    endtask : onTime
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic testModes();
        int n;
        wr(OWN_W, REG_BRIGHT0 + 5'h04, 8'h80, 1'b1);
        wr(OWN_W, REG_BRIGHT0 + 5'h05, 8'hFF, 1'b1);
        wr(OWN_W, REG_GROUP_DUTY, 8'h00, 1'b1);
        wr(OWN_W, REG_OUT_LO, 8'h55, 1'b1);
        wr(OWN_W, REG_OUT_HI, 8'h4E, 1'b1);
        check(ledOe & 8'hCF, 8'h8F);
        onTime(4, n);
        check(8'(n >= PWM_CYC - 8 && n <= PWM_CYC + 8), 8'h01);
        onTime(5, n);
        check(8'(n), 8'h00);
        wr(OWN_W, REG_GROUP_DUTY, 8'hFF, 1'b1);
        onTime(5, n);
        check(8'(n >= 2 * PWM_CYC - 8), 8'h01);
        wr(OWN_W, REG_BRIGHT0 + 5'h04, 8'h00, 1'b1);
        onTime(4, n);
        check(8'(n), 8'h00);
        $display("Output modes test done");
    endtask : testModes
    task automatic testAddr();
        wr(SUB_ADDR_RESET, REG_OUT_HI, 8'h00, 1'b0);
        wr(OWN_W ^ 8'h02, REG_OUT_HI, 8'h00, 1'b0);
        check(ledOe & 8'hC0, 8'h80);
        wr(GROUP_ADDR_RESET, REG_OUT_HI, 8'h00, 1'b1);
        check(ledOe & 8'hF0, 8'h00);
        wr(OWN_W, REG_MODE, 8'h13, 1'b1);
        wr(SUB_ADDR_RESET, REG_OUT_HI, 8'h40, 1'b1);
        check(ledOe & 8'hF0, 8'h80);
        $display("Address test done");
    endtask : testAddr
    // A counted spike would shift the data byte by one bit
    task automatic testSpike();
        i_master.start();
        tx(OWN_W, 1'b1);
        tx({3'h0, REG_OUT_LO}, 1'b1);
        i_master.spike();
        tx(8'h15, 1'b1);
        i_master.stop();
        check(ledOe & 8'h0F, 8'h07);
        $display("Spike filter test done");
    endtask : testSpike
    task automatic testSoft();
        i_master.start();
        tx(SOFT_W, 1'b1);
        tx(SOFT_RESET_KEY1, 1'b1);
        tx(SOFT_RESET_KEY2, 1'b1);
        tx(SOFT_RESET_KEY2, 1'b0);
        i_master.stop();
        check(ledOe, 8'h87);
        i_master.start();
        tx(SOFT_W, 1'b1);
        tx(8'h12, 1'b0);
        i_master.stop();
        check(ledOe, 8'h87);
        i_master.start();
        tx(SOFT_W, 1'b1);
        tx(SOFT_RESET_KEY1, 1'b1);
        tx(SOFT_RESET_KEY2, 1'b1);
        i_master.stop();
        check(ledOe, 8'h00);
        wr(SUB_ADDR_RESET, REG_OUT_LO, 8'h01, 1'b0);
        rd(REG_MODE, MODE_RESET, 8'h00);
        $display("Soft reset test done");
    endtask : testSoft
    task automatic testPin();
        wr(OWN_W, REG_OUT_LO, 8'h01, 1'b1);
        check(ledOe, 8'h01);
        check(ledOut, 8'h00);
        resetPinN = 1'b0;
        repeat (8) @(negedge clock);
        check(ledOe, 8'h00);
        wr(OWN_W, REG_OUT_LO, 8'h01, 1'b0);
        resetPinN = 1'b1;
        repeat (8) @(negedge clock);
        check(ledOe, 8'h00);
        wr(OWN_W, REG_OUT_LO, 8'h01, 1'b1);
        check(ledOe, 8'h01);
        $display("Reset pin test done");
    endtask : testPin
    // Second supply reset, issued only while the bus is idle
    task automatic testReset();
        reset = 1'b1;
        repeat (12) @(negedge clock);
        check(ledOe, 8'h00);
        reset = 1'b0;
        repeat (8) @(negedge clock);
        check(ledOe, 8'h00);
        check(8'(sdaOe), 8'h00);
        $display("Supply reset test done");
    endtask : testReset
    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial
    begin
        repeat (12) @(negedge clock);
        check(ledOe, 8'h00);
        check(8'(sdaOe), 8'h00);
        reset = 1'b0;
        repeat (8) @(negedge clock);
        testModes();
        testAddr();
        testSpike();
        testSoft();
        testPin();
        testReset();
        closeOut();
    end
    // Cuts a hang short and counts it as a mismatch
    initial
    begin
        repeat (100000) @(posedge clock);
        failCount++;
        closeOut();
    end
endmodule : eight_channel_led_pwm_driver_tb
